// ==== rtl/bec_core.sv ====
// Breakpoint comparators, performance counters and APB register file
// Functional notes
// - Fetch breakpoint: address, enable, translation bit
// - Fetch hit on address and translation match
// - Compare first byte address of issued instruction
// - Hit before execute, trace trap, status bit
// - Full data address compared with references
// - Compat view has no own storage
// - Compat view field layout: addr, DT, ST, LD
// - Data translation must equal match bit
// - Stores and block zeroing trigger when enabled
// - Loads trigger when read enable set
// - Compat write loads address, clears low bits
// - Compat write sets control bits and levels
// - Compat read merges control bits into address
// - Event select field positions, rest reserved
// - Source zero: 64-bit time base, quarter rate
// - Source one: counters hold
// - Above one: instructions high, event low
// - Event code decode, access or miss select
// - Freeze only affects time base source
// - Counters wrap to zero, never saturate
// - Mode register field positions, rest reserved
// - Upper bits exact, low three masked
// - User or kernel level enable required
// - Data hit without strobe: fault cause, address
// - Freeze stops time base, else fourth tick
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bec_core
  import bec_pkg::*;
(
  input wire logic pclk, // Processor clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic fetch_issue_valid, // Instruction attempting issue
  input wire logic [31:0] fetch_issue_addr, // Address of its first byte
  input wire logic fetch_xlate_state, // Instruction translation on
  output logic fetch_bp_hit, // Breakpoint, hold back issue
  output logic trap_save_status_bp, // Trace cause bit, registered
  input wire logic data_ref_valid, // Data reference present
  input wire logic [31:0] data_ref_addr, // Effective address
  input wire logic data_ref_load, // Reference is a load
  input wire logic data_ref_store, // Reference is a store
  input wire logic data_ref_zero_blk, // Reference is block zeroing
  input wire logic data_xlate_state, // Data translation on
  input wire logic user_state, // Processor in user state
  output logic data_bp_hit, // Data breakpoint, raise fault
  output logic data_bp_strobe, // Breakpoint in strobe mode
  input wire logic bus_tick, // One per bus cycle
  input wire logic insn_complete, // One per completed instruction
  input wire logic [5:0] cache_access, // Codes 4,5,8,9,10,11 accesses
  input wire logic [5:0] cache_miss, // Same codes, misses
  input wire logic [15:0] pipe_event_set1, // Codes 16-31, select set
  input wire logic [15:0] pipe_event_set0, // Codes 16-31, select clear
  output logic branch_guess_on, // Mode enable
  output logic diag_op_on, // Mode enable
  output logic overlap_issue_on, // Mode enable
  output logic multi_issue_on // Mode enable
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0] fetch_bp_q, fetch_bp_d;
  logic [31:0] data_addr_q, data_addr_d;
  logic [8:0] ctl_q, ctl_d;
  logic [5:0] evt_q, evt_d;
  logic [4:0] mode_q, mode_d;
  logic [31:0] cnt_hi_q, cnt_hi_d;
  logic [31:0] cnt_lo_q, cnt_lo_d;
  logic [1:0] tb_div_q, tb_div_d;
  logic trap_q, trap_d;
  logic fault_q, fault_d;
  logic [31:0] fault_addr_q, fault_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;

  logic wr_en;
  logic rd_setup;
  logic [31:0] cmp_view;
  logic [2:0] mask;
  logic addr_match;
  logic dir_ok;
  logic lvl_ok;
  logic data_hit_raw;
  logic [4:0] src;
  logic set_sel;
  logic evt_pick;
  logic tb_step;
  logic [63:0] tb_next;
  logic mapped;

  // ****************************************
  // Bus decode
  // ****************************************
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign prdata = rdata_q;
  assign pslverr = err_q;

  always_comb begin
    unique case (paddr)
      BEC_OFS_FETCH_BP, BEC_OFS_DATA_BP_ADDR, BEC_OFS_DATA_BP_COMPAT, BEC_OFS_BP_CTRL,
      BEC_OFS_EVENT_SEL, BEC_OFS_MODE_CTRL, BEC_OFS_COUNT_HIGH, BEC_OFS_COUNT_LOW,
      BEC_OFS_FAULT_STAT, BEC_OFS_FAULT_ADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Compat view built from the full address and control bits
  always_comb begin
    cmp_view = data_addr_q;
    cmp_view[BEC_CTL_DT] = ctl_q[BEC_CTL_DT];
    cmp_view[BEC_CTL_ST] = ctl_q[BEC_CTL_ST];
    cmp_view[BEC_CTL_LD] = ctl_q[BEC_CTL_LD];
  end

  // ****************************************
  // Fetch breakpoint
  // ****************************************
  always_comb begin
    fetch_bp_hit = fetch_issue_valid & fetch_bp_q[BEC_FBP_ON]
      & (fetch_issue_addr[31:BEC_FBP_ADDR_LSB] == fetch_bp_q[31:BEC_FBP_ADDR_LSB])
      & (fetch_xlate_state == fetch_bp_q[BEC_FBP_XLATE]);
  end
  assign trap_save_status_bp = trap_q;

  // ****************************************
  // Data breakpoint
  // ****************************************
  assign mask = ctl_q[BEC_CTL_MASK_LSB +: 3];
  always_comb begin
    if (data_ref_zero_blk) begin
      // Block zeroing covers the whole 32-byte block
      addr_match = (data_ref_addr[31:5] == data_addr_q[31:5]);
    end else begin
      addr_match = (data_ref_addr[31:3] == data_addr_q[31:3])
        & ((data_ref_addr[2:0] & mask) == (data_addr_q[2:0] & mask));
    end
  end
  assign dir_ok = (data_ref_load & ctl_q[BEC_CTL_LD])
    | ((data_ref_store | data_ref_zero_blk) & ctl_q[BEC_CTL_ST]);
  assign lvl_ok = (user_state & ctl_q[BEC_CTL_PR])
    | (~user_state & ctl_q[BEC_CTL_SU]);
  assign data_hit_raw = data_ref_valid & addr_match & dir_ok & lvl_ok
    & (data_xlate_state == ctl_q[BEC_CTL_DT]);
  assign data_bp_hit = data_hit_raw & ~ctl_q[BEC_CTL_SB];
  assign data_bp_strobe = data_hit_raw & ctl_q[BEC_CTL_SB];

  // ****************************************
  // Event selection
  // ****************************************
  assign src = evt_q[4:0];
  assign set_sel = evt_q[5];
  always_comb begin
    evt_pick = 1'b0;
    unique case (src)
      5'h04: evt_pick = set_sel ? cache_access[0] : cache_miss[0];
      5'h05: evt_pick = set_sel ? cache_access[1] : cache_miss[1];
      5'h08: evt_pick = set_sel ? cache_access[2] : cache_miss[2];
      5'h09: evt_pick = set_sel ? cache_access[3] : cache_miss[3];
      5'h0A: evt_pick = set_sel ? cache_access[4] : cache_miss[4];
      5'h0B: evt_pick = set_sel ? cache_access[5] : cache_miss[5];
      default: begin
        if (src >= BEC_SRC_PIPE_FIRST) begin
          evt_pick = set_sel ? pipe_event_set1[src[3:0]] : pipe_event_set0[src[3:0]];
        end
      end
    endcase
  end

  // Every fourth bus cycle, unless frozen
  assign tb_step = bus_tick & (tb_div_q == BEC_TB_DIV_LAST)
    & ~mode_q[BEC_MOD_TBD - BEC_MOD_SSE];
  assign tb_next = {cnt_hi_q, cnt_lo_q} + 64'h0000_0000_0000_0001;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    fetch_bp_d = fetch_bp_q;
    data_addr_d = data_addr_q;
    ctl_d = ctl_q;
    evt_d = evt_q;
    mode_d = mode_q;
    cnt_hi_d = cnt_hi_q;
    cnt_lo_d = cnt_lo_q;
    tb_div_d = tb_div_q;
    trap_d = trap_q;
    fault_d = fault_q;
    fault_addr_d = fault_addr_q;
    rdata_d = rdata_q;
    err_d = 1'b0;

    if (fetch_bp_hit) begin
      trap_d = 1'b1;
    end
    if (data_bp_hit) begin
      fault_d = 1'b1;
      fault_addr_d = data_ref_addr;
    end

    // Counters
    if (bus_tick) begin
      tb_div_d = tb_div_q + 2'h1;
    end
    if (src == BEC_SRC_TIME) begin
      if (tb_step) begin
        cnt_hi_d = tb_next[63:32];
        cnt_lo_d = tb_next[31:0];
      end
    end else if (src != BEC_SRC_HOLD) begin
      if (insn_complete) begin
        cnt_hi_d = cnt_hi_q + 32'h0000_0001;
      end
      if (evt_pick) begin
        cnt_lo_d = cnt_lo_q + 32'h0000_0001;
      end
    end

    // Register writes take effect at the access edge
    if (wr_en) begin
      unique case (paddr)
        BEC_OFS_FETCH_BP: fetch_bp_d = pwdata;
        BEC_OFS_DATA_BP_ADDR: data_addr_d = pwdata;
        BEC_OFS_DATA_BP_COMPAT: begin
          data_addr_d = {pwdata[31:BEC_CMP_ADDR_LSB], 3'h0};
          ctl_d[BEC_CTL_DT] = pwdata[BEC_CTL_DT];
          ctl_d[BEC_CTL_ST] = pwdata[BEC_CTL_ST];
          ctl_d[BEC_CTL_LD] = pwdata[BEC_CTL_LD];
          ctl_d[BEC_CTL_PR] = 1'b1;
          ctl_d[BEC_CTL_SU] = 1'b1;
        end
        BEC_OFS_BP_CTRL: ctl_d = pwdata[8:0];
        BEC_OFS_EVENT_SEL: evt_d = pwdata[BEC_EVT_SET:BEC_EVT_SRC_LSB];
        BEC_OFS_MODE_CTRL: mode_d = pwdata[BEC_MOD_BPE:BEC_MOD_SSE];
        BEC_OFS_COUNT_HIGH: cnt_hi_d = pwdata;
        BEC_OFS_COUNT_LOW: cnt_lo_d = pwdata;
        BEC_OFS_FAULT_STAT: begin
          // Write one clears; a new event in the same cycle wins
          if (pwdata[BEC_TRAP_SAVE_BIT] && !fetch_bp_hit) begin
            trap_d = 1'b0;
          end
          if (pwdata[BEC_FAULT_CAUSE_BIT] && !data_bp_hit) begin
            fault_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Read data captured in the setup cycle
    if (rd_setup) begin
      err_d = ~mapped;
      unique case (paddr)
        BEC_OFS_FETCH_BP: rdata_d = fetch_bp_q;
        BEC_OFS_DATA_BP_ADDR: rdata_d = data_addr_q;
        BEC_OFS_DATA_BP_COMPAT: rdata_d = cmp_view;
        BEC_OFS_BP_CTRL: rdata_d = {23'h0, ctl_q} & BEC_CTL_WMASK;
        BEC_OFS_EVENT_SEL: rdata_d = {18'h0, evt_q, 8'h0} & BEC_EVT_WMASK;
        BEC_OFS_MODE_CTRL: rdata_d = {11'h0, mode_q, 16'h0} & BEC_MOD_WMASK;
        BEC_OFS_COUNT_HIGH: rdata_d = cnt_hi_q;
        BEC_OFS_COUNT_LOW: rdata_d = cnt_lo_q;
        BEC_OFS_FAULT_STAT: begin
          rdata_d = BEC_RST_WORD;
          rdata_d[BEC_TRAP_SAVE_BIT] = trap_q;
          rdata_d[BEC_FAULT_CAUSE_BIT] = fault_q;
        end
        BEC_OFS_FAULT_ADDR: rdata_d = fault_addr_q;
        default: rdata_d = BEC_RST_WORD;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_bp_q <= BEC_RST_WORD;
      data_addr_q <= BEC_RST_WORD;
      ctl_q <= 9'h000;
      evt_q <= 6'h00;
      mode_q <= 5'h00;
      cnt_hi_q <= BEC_RST_WORD;
      cnt_lo_q <= BEC_RST_WORD;
      tb_div_q <= 2'h0;
      trap_q <= 1'b0;
      fault_q <= 1'b0;
      fault_addr_q <= BEC_RST_WORD;
      rdata_q <= BEC_RST_WORD;
      err_q <= 1'b0;
    end else begin
      fetch_bp_q <= fetch_bp_d;
      data_addr_q <= data_addr_d;
      ctl_q <= ctl_d;
      evt_q <= evt_d;
      mode_q <= mode_d;
      cnt_hi_q <= cnt_hi_d;
      cnt_lo_q <= cnt_lo_d;
      tb_div_q <= tb_div_d;
      trap_q <= trap_d;
      fault_q <= fault_d;
      fault_addr_q <= fault_addr_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // ****************************************
  // Mode outputs
  // ****************************************
  assign branch_guess_on = mode_q[BEC_MOD_BPE - BEC_MOD_SSE];
  assign diag_op_on = mode_q[BEC_MOD_DE - BEC_MOD_SSE];
  assign overlap_issue_on = mode_q[BEC_MOD_POE - BEC_MOD_SSE];
  assign multi_issue_on = mode_q[0];

endmodule
`default_nettype wire

// ==== rtl/bec_pkg.sv ====
// Package with register map, field positions and reset values for the breakpoint/event block
package bec_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] BEC_OFS_FETCH_BP = 8'h00;
  localparam logic [7:0] BEC_OFS_DATA_BP_ADDR = 8'h04;
  localparam logic [7:0] BEC_OFS_DATA_BP_COMPAT = 8'h08;
  localparam logic [7:0] BEC_OFS_BP_CTRL = 8'h0C;
  localparam logic [7:0] BEC_OFS_EVENT_SEL = 8'h10;
  localparam logic [7:0] BEC_OFS_MODE_CTRL = 8'h14;
  localparam logic [7:0] BEC_OFS_COUNT_HIGH = 8'h18;
  localparam logic [7:0] BEC_OFS_COUNT_LOW = 8'h1C;
  localparam logic [7:0] BEC_OFS_FAULT_STAT = 8'h20;
  localparam logic [7:0] BEC_OFS_FAULT_ADDR = 8'h24;

  // ****************************************
  // Field positions (LSB-0 numbering)
  // ****************************************
  localparam int BEC_FBP_ON = 1;
  localparam int BEC_FBP_XLATE = 0;
  localparam int BEC_FBP_ADDR_LSB = 2;
  localparam int BEC_CMP_ADDR_LSB = 3;
  localparam int BEC_CTL_LD = 0;
  localparam int BEC_CTL_ST = 1;
  localparam int BEC_CTL_DT = 2;
  localparam int BEC_CTL_SU = 3;
  localparam int BEC_CTL_PR = 4;
  localparam int BEC_CTL_SB = 5;
  localparam int BEC_CTL_MASK_LSB = 6;
  localparam int BEC_EVT_SET = 13;
  localparam int BEC_EVT_SRC_LSB = 8;
  localparam int BEC_MOD_BPE = 20;
  localparam int BEC_MOD_TBD = 19;
  localparam int BEC_MOD_DE = 18;
  localparam int BEC_MOD_POE = 17;
  localparam int BEC_MOD_SSE = 16;
  localparam int BEC_TRAP_SAVE_BIT = 20;
  localparam int BEC_FAULT_CAUSE_BIT = 22;

  // ****************************************
  // Writable masks and reset values
  // ****************************************
  localparam logic [31:0] BEC_CTL_WMASK = 32'h0000_01FF;
  localparam logic [31:0] BEC_EVT_WMASK = 32'h0000_3F00;
  localparam logic [31:0] BEC_MOD_WMASK = 32'h001F_0000;
  localparam logic [31:0] BEC_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] BEC_TB_DIV_LAST = 2'h3;

  // ****************************************
  // Event codes
  // ****************************************
  localparam logic [4:0] BEC_SRC_TIME = 5'h00;
  localparam logic [4:0] BEC_SRC_HOLD = 5'h01;
  localparam logic [4:0] BEC_SRC_PIPE_FIRST = 5'h10;
endpackage

// ==== verif/bec_core_props.sv ====
// Checker with concurrent properties for the breakpoint and event block
`timescale 1ns/1ps
`default_nettype none
module bec_core_props
  import bec_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pslverr, // APB error
  input wire logic fetch_issue_valid, // Issue attempt
  input wire logic fetch_bp_hit, // Fetch hit
  input wire logic trap_save_status_bp, // Trace cause bit
  input wire logic data_ref_valid, // Data reference
  input wire logic data_ref_load, // Load
  input wire logic data_ref_store, // Store
  input wire logic data_ref_zero_blk, // Block zeroing
  input wire logic data_bp_hit, // Data hit
  input wire logic data_bp_strobe // Strobe hit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_fault = psel && penable && pwrite && paddr == BEC_OFS_FAULT_STAT;
  // ****************************************
  // Properties
  // ****************************************
  a_fetch_hit_cause: assert property (fetch_bp_hit |-> fetch_issue_valid)
    else $error("fetch hit without issue");
  a_trace_after_hit: assert property (fetch_bp_hit |=> trap_save_status_bp)
    else $error("trace bit not set after hit");
  a_trace_rise_cause: assert property (
    $rose(trap_save_status_bp) |-> $past(fetch_bp_hit))
    else $error("trace bit set without hit");
  a_trace_clear_write: assert property (
    $fell(trap_save_status_bp) |-> $past(wr_fault && pwdata[BEC_TRAP_SAVE_BIT]))
    else $error("trace bit lost without clear");
  a_data_ref_kind: assert property ((data_bp_hit || data_bp_strobe) |->
    data_ref_valid && (data_ref_load || data_ref_store || data_ref_zero_blk))
    else $error("data hit without reference");
  a_hit_strobe_excl: assert property (!(data_bp_hit && data_bp_strobe))
    else $error("fault and strobe together");
  a_reset_quiet: assert property (
    !$past(presetn) |-> !fetch_bp_hit && !data_bp_hit && !data_bp_strobe)
    else $error("hit right after reset");
  a_err_access_only: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > BEC_OFS_FAULT_ADDR))
    else $error("slave error wrong");
  c_fetch: cover property (fetch_bp_hit);
  c_data: cover property (data_bp_hit);
  c_strobe: cover property (data_bp_strobe);
  c_clear: cover property ($fell(trap_save_status_bp));
endmodule
bind bec_core bec_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .fetch_issue_valid(fetch_issue_valid), .fetch_bp_hit(fetch_bp_hit),
  .trap_save_status_bp(trap_save_status_bp), .data_ref_valid(data_ref_valid),
  .data_ref_load(data_ref_load), .data_ref_store(data_ref_store),
  .data_ref_zero_blk(data_ref_zero_blk), .data_bp_hit(data_bp_hit), .data_bp_strobe(data_bp_strobe));
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench for the breakpoint and event block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, fetch_issue_addr, data_ref_addr;
  logic fetch_issue_valid, fetch_xlate_state, fetch_bp_hit, trap_save_status_bp;
  logic data_ref_valid, data_ref_load, data_ref_store, data_ref_zero_blk;
  logic data_xlate_state, user_state, data_bp_hit, data_bp_strobe, bus_tick, insn_complete;
  logic [5:0] cache_access, cache_miss;
  logic [15:0] pipe_event_set1, pipe_event_set0;
  logic branch_guess_on, diag_op_on, overlap_issue_on, multi_issue_on;
  logic [4:0] code_tbl [6] = '{5'h04, 5'h05, 5'h08, 5'h09, 5'h0A, 5'h0B};
  logic [21:0] hot;
  logic [4:0] code;
  int fail_count, cmp_count, i, j, s;
  bec_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_issue_valid(fetch_issue_valid), .fetch_issue_addr(fetch_issue_addr),
    .fetch_xlate_state(fetch_xlate_state), .fetch_bp_hit(fetch_bp_hit),
    .trap_save_status_bp(trap_save_status_bp), .data_ref_valid(data_ref_valid),
    .data_ref_addr(data_ref_addr), .data_ref_load(data_ref_load), .data_ref_store(data_ref_store),
    .data_ref_zero_blk(data_ref_zero_blk), .data_xlate_state(data_xlate_state),
    .user_state(user_state), .data_bp_hit(data_bp_hit), .data_bp_strobe(data_bp_strobe),
    .bus_tick(bus_tick), .insn_complete(insn_complete), .cache_access(cache_access),
    .cache_miss(cache_miss), .pipe_event_set1(pipe_event_set1), .pipe_event_set0(pipe_event_set0),
    .branch_guess_on(branch_guess_on), .diag_op_on(diag_op_on),
    .overlap_issue_on(overlap_issue_on), .multi_issue_on(multi_issue_on));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk1(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
    if (n == 16) begin
      chk1("pready", 1'b1, 1'b0);
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk32($sformatf("register %h", a), exp, rdat);
  endtask
  task automatic fref(input logic [31:0] a, input logic xl, input logic eh);
    @(posedge pclk);
    {fetch_issue_valid, fetch_issue_addr, fetch_xlate_state} <= {1'b1, a, xl};
    @(negedge pclk);
    chk1("fetch_bp_hit", eh, fetch_bp_hit);
    @(posedge pclk);
    fetch_issue_valid <= 1'b0;
  endtask
  task automatic dref(input logic [31:0] a, input logic [2:0] k, input logic xl, input logic us,
                      input logic eh, input logic es);
    @(posedge pclk);
    {data_ref_valid, data_ref_addr, data_ref_zero_blk, data_ref_store, data_ref_load} <= {1'b1, a, k};
    {data_xlate_state, user_state} <= {xl, us};
    @(negedge pclk);
    chk1("data_bp_hit", eh, data_bp_hit);
    chk1("data_bp_strobe", es, data_bp_strobe);
    @(posedge pclk);
    data_ref_valid <= 1'b0;
  endtask
  task automatic ev(input logic [5:0] ac, input logic [5:0] mi, input logic [15:0] p1,
                    input logic [15:0] p0, input logic tk, input logic ins, input int n);
    @(posedge pclk);
    {cache_access, cache_miss, pipe_event_set1, pipe_event_set0, bus_tick, insn_complete}
      <= {ac, mi, p1, p0, tk, ins};
    repeat (n) @(posedge pclk);
    {cache_access, cache_miss, pipe_event_set1, pipe_event_set0, bus_tick, insn_complete} <= '0;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fetch_issue_valid, fetch_issue_addr, fetch_xlate_state} = '0;
    {data_ref_valid, data_ref_addr, data_ref_load, data_ref_store, data_ref_zero_blk} = '0;
    {data_xlate_state, user_state} = '0;
    {cache_access, cache_miss, pipe_event_set1, pipe_event_set0, bus_tick, insn_complete} = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 10; i++) rd(8'(i * 4), BEC_RST_WORD);
    rd(8'h28, 32'h0000_0000);
    chk1("pslverr", 1'b1, rerr);
    // Compat view writes and reads
    wr(BEC_OFS_DATA_BP_COMPAT, 32'h0000_2007);
    rd(BEC_OFS_DATA_BP_ADDR, 32'h0000_2000);
    rd(BEC_OFS_BP_CTRL, 32'h0000_001F);
    rd(BEC_OFS_DATA_BP_COMPAT, 32'h0000_2007);
    dref(32'h0000_2004, 3'b001, 1'b1, 1'b0, 1'b1, 1'b0);
    dref(32'h0000_2004, 3'b001, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(BEC_OFS_DATA_BP_ADDR, 32'h0000_2005);
    wr(BEC_OFS_BP_CTRL, 32'h0000_01DB);
    rd(BEC_OFS_DATA_BP_COMPAT, 32'h0000_2003);
    rd(BEC_OFS_DATA_BP_ADDR, 32'h0000_2005);
    dref(32'h0000_2005, 3'b001, 1'b0, 1'b1, 1'b1, 1'b0);
    dref(32'h8000_2005, 3'b001, 1'b0, 1'b1, 1'b0, 1'b0);
    dref(32'h0000_2004, 3'b001, 1'b0, 1'b1, 1'b0, 1'b0);
    dref(32'h0000_2005, 3'b010, 1'b0, 1'b1, 1'b1, 1'b0);
    wr(BEC_OFS_BP_CTRL, 32'h0000_01D9);
    dref(32'h0000_2005, 3'b010, 1'b0, 1'b1, 1'b0, 1'b0);
    wr(BEC_OFS_DATA_BP_ADDR, 32'h0000_2000);
    wr(BEC_OFS_BP_CTRL, 32'h0000_000A);
    dref(32'h0000_2018, 3'b100, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(BEC_OFS_FAULT_STAT, 32'h0040_0000);
    rd(BEC_OFS_FAULT_ADDR, 32'h0000_2018);
    dref(32'h0000_2000, 3'b001, 1'b0, 1'b0, 1'b0, 1'b0);
    dref(32'h0000_2000, 3'b010, 1'b0, 1'b1, 1'b0, 1'b0);
    wr(BEC_OFS_BP_CTRL, 32'h0000_002A);
    dref(32'h0000_2000, 3'b010, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(BEC_OFS_FAULT_STAT, 32'h0040_0000);
    rd(BEC_OFS_FAULT_STAT, 32'h0000_0000);
    // Fetch breakpoint; the write completes before the first issue
    wr(BEC_OFS_FETCH_BP, 32'h0000_1003);
    rd(BEC_OFS_FETCH_BP, 32'h0000_1003);
    fref(32'h0000_1000, 1'b1, 1'b1);
    fref(32'h0000_1004, 1'b1, 1'b0);
    fref(32'h0000_1000, 1'b0, 1'b0);
    chk1("trap_save_status_bp", 1'b1, trap_save_status_bp);
    rd(BEC_OFS_FAULT_STAT, 32'h0010_0000);
    wr(BEC_OFS_FAULT_STAT, 32'h0010_0000);
    rd(BEC_OFS_FAULT_STAT, 32'h0000_0000);
    chk1("trap_save_status_bp", 1'b0, trap_save_status_bp);
    // Time base and event counting
    wr(BEC_OFS_COUNT_LOW, 32'hFFFF_FFFF);
    wr(BEC_OFS_COUNT_HIGH, 32'h0000_0005);
    ev('0, '0, '0, '0, 1'b1, 1'b1, 8);
    rd(BEC_OFS_COUNT_LOW, 32'h0000_0001);
    rd(BEC_OFS_COUNT_HIGH, 32'h0000_0006);
    wr(BEC_OFS_MODE_CTRL, 32'h0008_0000);
    ev('0, '0, '0, '0, 1'b1, 1'b0, 4);
    rd(BEC_OFS_COUNT_LOW, 32'h0000_0001);
    wr(BEC_OFS_EVENT_SEL, 32'h0000_0100);
    ev('1, '1, '1, '1, 1'b1, 1'b1, 4);
    rd(BEC_OFS_COUNT_LOW, 32'h0000_0001);
    rd(BEC_OFS_COUNT_HIGH, 32'h0000_0006);
    wr(BEC_OFS_EVENT_SEL, 32'h0000_2400);
    ev(6'h01, 6'h3E, '0, '0, 1'b1, 1'b1, 3);
    rd(BEC_OFS_COUNT_LOW, 32'h0000_0004);
    rd(BEC_OFS_COUNT_HIGH, 32'h0000_0009);
    for (j = 0; j < 22; j++) begin
      for (s = 0; s < 2; s++) begin
        code = (j < 6) ? code_tbl[j] : 5'(j + 10);
        hot = 22'h1 << j;
        wr(BEC_OFS_EVENT_SEL, {18'h0, s[0], code, 8'h00});
        wr(BEC_OFS_COUNT_LOW, 32'h0000_0000);
        ev(s[0] ? hot[5:0] : ~hot[5:0], s[0] ? ~hot[5:0] : hot[5:0],
           s[0] ? hot[21:6] : ~hot[21:6], s[0] ? ~hot[21:6] : hot[21:6], 1'b1, 1'b0, 2);
        rd(BEC_OFS_COUNT_LOW, 32'h0000_0002);
      end
    end
    // Reserved bits of mode and event select
    wr(BEC_OFS_MODE_CTRL, 32'hFFFF_FFFF);
    rd(BEC_OFS_MODE_CTRL, BEC_MOD_WMASK);
    chk1("branch_guess_on", 1'b1, branch_guess_on);
    chk1("diag_op_on", 1'b1, diag_op_on);
    chk1("overlap_issue_on", 1'b1, overlap_issue_on);
    chk1("multi_issue_on", 1'b1, multi_issue_on);
    wr(BEC_OFS_EVENT_SEL, 32'hFFFF_FFFF);
    rd(BEC_OFS_EVENT_SEL, BEC_EVT_WMASK);
    // Reset in mid-run with breakpoints armed
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(BEC_OFS_FETCH_BP, 32'h0000_0000);
    rd(BEC_OFS_BP_CTRL, 32'h0000_0000);
    fref(32'h0000_1000, 1'b1, 1'b0);
    chk1("multi_issue_on", 1'b0, multi_issue_on);
    conclude();
  end
endmodule
`default_nettype wire
